// File: inc/eid_params.svh
// Constants of the external interrupt detector
//------------------------------------------------------------
// Notes on behaviour
//------------------------------------------------------------
// Notes on behaviour
// - Eight pin channels are watched, and a request is raised when a channel's selected condition appears.
// - Each channel picks low level, high level, rising edge or falling edge on its own two select bits.
// - A channel whose enable bit is clear never signals the CPU side.
// - A detected event is held as a pending flag that software reads back in the request register.
// - Channels pair up as 0/1, 2/3, 4/5 and 6/7 onto interrupt numbers 25, 26, 27 and 28.
// - With the number's auto transfer bit at 1 a data transfer runs before the handler request; at 0 it goes direct.
`ifndef EID_PARAMS_SVH
`define EID_PARAMS_SVH

//------------------------------------------------------------
// Sizes
//------------------------------------------------------------
`define EID_NCH          8
`define EID_NIRQ         4
`define EID_HSIZE_WORD   3'h2

//------------------------------------------------------------
// Register byte offsets
//------------------------------------------------------------
`define EID_OFS_LEVEL    8'h00
`define EID_OFS_ENABLE   8'h04
`define EID_OFS_REQUEST  8'h08
`define EID_OFS_CTL_LO   8'h0C
`define EID_OFS_CTL_HI   8'h10
`define EID_OFS_STATUS   8'h14
`define EID_OFS_MASK     8'h18

//------------------------------------------------------------
// Reset values and codes
//------------------------------------------------------------
`define EID_RST_LEVEL    16'h0000
`define EID_RST_BYTE     8'h00
`define EID_RST_PAIR     2'h0
`define EID_IRQ_FIRST    8'h19
`define EID_IRQ_LAST     8'h1C
`define EID_MODE_LOW     2'h0
`define EID_MODE_HIGH    2'h1
`define EID_MODE_RISE    2'h2
`define EID_MODE_FALL    2'h3

`endif

// File: inc/eid_pkg.sv
// Types and helper functions of the external interrupt detector
`include "eid_params.svh"
package eid_pkg;

	//------------------------------------------------------------
	// Types
	//------------------------------------------------------------
	typedef enum logic [1:0] {
		EID_LOW  = `EID_MODE_LOW,
		EID_HIGH = `EID_MODE_HIGH,
		EID_RISE = `EID_MODE_RISE,
		EID_FALL = `EID_MODE_FALL
	} eid_mode_t;

	typedef enum logic [1:0] {
		EID_ST_IDLE = 2'h1,
		EID_ST_XFER = 2'h2
	} eid_xfer_st_t;

	//------------------------------------------------------------
	// Functions
	//------------------------------------------------------------
	function automatic logic eid_hit(input logic [1:0] mode, input logic cur, input logic prev);
		eid_hit = (mode == EID_LOW)  ? ~cur :
		          (mode == EID_HIGH) ? cur :
		          (mode == EID_RISE) ? (cur & ~prev) : (~cur & prev);
	endfunction : eid_hit

	function automatic logic [1:0] eid_pick(input logic [3:0] v);
		eid_pick = v[0] ? 2'h0 : v[1] ? 2'h1 : v[2] ? 2'h2 : 2'h3;
	endfunction : eid_pick

endpackage : eid_pkg

// File: inc/eid_det_if.sv
// Link between pin detection and the request logic
`timescale 1ns/10ps
`include "eid_params.svh"
interface eid_det_if;
	logic [2*`EID_NCH-1:0] level_sel;
	logic [`EID_NCH-1:0]   hit;

	modport main (output level_sel, input hit);
	modport det  (input level_sel, output hit);
endinterface : eid_det_if

// File: logic/eid_detect.sv
// Pin synchronisers and per-channel condition detection
`timescale 1ns/10ps
`include "eid_params.svh"
module eid_detect
	import eid_pkg::*;
(
	// Clock and reset
	input  wire logic                hclk,
	input  wire logic                hresetn,
	// External pins
	input  wire logic [`EID_NCH-1:0] pins,
	// Toward the request logic
	eid_det_if.det                   bus
);

	//------------------------------------------------------------
	// Synchronisers
	//------------------------------------------------------------
	logic [`EID_NCH-1:0] sync_a;
	logic [`EID_NCH-1:0] sync_b;
	logic [`EID_NCH-1:0] prev;
	logic [2:0]          vld;

	// Hits wait for a settled history, so no false edge follows reset
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sync_a <= `EID_RST_BYTE;
			sync_b <= `EID_RST_BYTE;
			prev   <= `EID_RST_BYTE;
			vld    <= 3'h0;
		end else begin
			sync_a <= pins;
			sync_b <= sync_a;
			prev   <= sync_b;
			vld    <= {vld[1:0], 1'b1};
		end
	end

	//------------------------------------------------------------
	// Detection
	//------------------------------------------------------------
	genvar i;
	generate
		for (i = 0; i < `EID_NCH; i++) begin : g_ch
			assign bus.hit[i] = vld[2] & eid_hit(bus.level_sel[2*i+1:2*i], sync_b[i], prev[i]);
		end
	endgenerate

	//------------------------------------------------------------
	// Checks
	//------------------------------------------------------------
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	a_rise_detect: assert property (vld[2] && bus.level_sel[1:0] == `EID_MODE_RISE && sync_b[0] && !prev[0]
		|-> bus.hit[0]) else $error("rising edge on channel 0 missed");
	a_fall_quiet: assert property (bus.level_sel[3:2] == `EID_MODE_FALL && !($fell(sync_b[1]))
		|-> !bus.hit[1]) else $error("falling detect hit without a fall");

endmodule : eid_detect

// File: logic/eid_top.sv
// External interrupt detector with AHB-Lite register slave
//
// Design decisions made here: the AHB-Lite interface to the registers and the placing of the registers.
`timescale 1ns/10ps
`include "eid_params.svh"
module eid_top
	import eid_pkg::*;
(
	// Clock and reset
	input  wire logic                 hclk,
	input  wire logic                 hresetn,
	// AHB-Lite slave
	input  wire logic                 hsel,
	input  wire logic [31:0]          haddr,
	input  wire logic [1:0]           htrans,
	input  wire logic                 hwrite,
	input  wire logic [2:0]           hsize,
	input  wire logic [31:0]          hwdata,
	input  wire logic                 hready,
	output logic      [31:0]          hrdata,
	output logic                      hreadyout,
	output logic                      hresp,
	// External interrupt pins
	input  wire logic [`EID_NCH-1:0]  ext_irq_inputs,
	// Toward the CPU interrupt system
	output logic      [`EID_NIRQ-1:0] irq_req,
	output logic                      xfer_req,
	output logic      [7:0]           xfer_num,
	input  wire logic                 xfer_ack,
	// Summary interrupt
	output logic                      irq
);

	//------------------------------------------------------------
	// Registers
	//------------------------------------------------------------
	logic [2*`EID_NCH-1:0] detect_level_select;
	logic [`EID_NCH-1:0]   ext_irq_enable;
	logic [`EID_NCH-1:0]   ext_irq_request_reg;
	logic [1:0]            irq_control_low_pairs;
	logic [1:0]            irq_control_high_pairs;
	logic [7:0]            irq_status;
	logic [7:0]            irq_mask;

	//------------------------------------------------------------
	// Internal state
	//------------------------------------------------------------
	logic                  wr_pend;
	logic                  rd_pend;
	logic [7:0]            acc_addr;
	logic [`EID_NIRQ-1:0]  served;
	logic [`EID_NIRQ-1:0]  pair_req_d;
	logic [1:0]            cur;
	eid_xfer_st_t          state;

	//------------------------------------------------------------
	// Pin detection
	//------------------------------------------------------------
	eid_det_if det_bus ();

	eid_detect u_detect (
		.hclk    (hclk),
		.hresetn (hresetn),
		.pins    (ext_irq_inputs),
		.bus     (det_bus.det)
	);

	assign det_bus.level_sel = detect_level_select;

	//------------------------------------------------------------
	// Bus decode
	//------------------------------------------------------------
	wire        acc      = hsel & hready & htrans[1] & (hsize == `EID_HSIZE_WORD);
	wire        wr_level = wr_pend & (acc_addr == `EID_OFS_LEVEL);
	wire        wr_en    = wr_pend & (acc_addr == `EID_OFS_ENABLE);
	wire        wr_req   = wr_pend & (acc_addr == `EID_OFS_REQUEST);
	wire        wr_ctl_l = wr_pend & (acc_addr == `EID_OFS_CTL_LO);
	wire        wr_ctl_h = wr_pend & (acc_addr == `EID_OFS_CTL_HI);
	wire        wr_stat  = wr_pend & (acc_addr == `EID_OFS_STATUS);
	wire        wr_mask  = wr_pend & (acc_addr == `EID_OFS_MASK);

	wire [31:0] rd_word  =
		(acc_addr == `EID_OFS_LEVEL)   ? {16'h0000, detect_level_select} :
		(acc_addr == `EID_OFS_ENABLE)  ? {24'h000000, ext_irq_enable} :
		(acc_addr == `EID_OFS_REQUEST) ? {24'h000000, ext_irq_request_reg} :
		(acc_addr == `EID_OFS_CTL_LO)  ? {30'h00000000, irq_control_low_pairs} :
		(acc_addr == `EID_OFS_CTL_HI)  ? {30'h00000000, irq_control_high_pairs} :
		(acc_addr == `EID_OFS_STATUS)  ? {24'h000000, irq_status} :
		(acc_addr == `EID_OFS_MASK)    ? {24'h000000, irq_mask} : 32'h00000000;

	// One wait state on reads, so a write just before is seen
	wire        next_hreadyout = ~(acc & ~hwrite);

	//------------------------------------------------------------
	// Request flags and pairing
	//------------------------------------------------------------
	wire [`EID_NCH-1:0]  req_clr      = wr_req ? ~hwdata[`EID_NCH-1:0] : `EID_RST_BYTE;
	// Set beats clear, a level channel keeps re-setting while active
	wire [`EID_NCH-1:0]  next_req     = (ext_irq_request_reg & ~req_clr) | det_bus.hit;
	wire [`EID_NCH-1:0]  ext_irq_request_flags = ext_irq_request_reg & ext_irq_enable;

	wire [`EID_NIRQ-1:0] pair_req = {
		|ext_irq_request_flags[7:6],
		|ext_irq_request_flags[5:4],
		|ext_irq_request_flags[3:2],
		|ext_irq_request_flags[1:0]
	};

	wire [`EID_NIRQ-1:0] auto_transfer_select = {irq_control_high_pairs, irq_control_low_pairs};

	//------------------------------------------------------------
	// Transfer sequencing
	//------------------------------------------------------------
	wire [`EID_NIRQ-1:0] want      = pair_req & auto_transfer_select & ~served;
	wire                 start     = (state == EID_ST_IDLE) & (|want);
	wire [1:0]           pick      = eid_pick(want);
	wire                 done      = (state == EID_ST_XFER) & xfer_ack;
	wire [`EID_NIRQ-1:0] done_vec  = done ? (4'h1 << cur) : 4'h0;
	// Served marks drop with the request, ready for the next one
	wire [`EID_NIRQ-1:0] next_served = (served | done_vec) & pair_req;

	wire eid_xfer_st_t   next_state =
		start ? EID_ST_XFER :
		done  ? EID_ST_IDLE : state;

	wire [7:0]           next_num  = `EID_IRQ_FIRST + {6'h00, pick};

	// Handler request only once any transfer for that number is done
	wire [`EID_NIRQ-1:0] next_irq_req = pair_req & (~auto_transfer_select | served);

	//------------------------------------------------------------
	// Status and summary interrupt
	//------------------------------------------------------------
	wire [7:0]           evt         = {done_vec, pair_req & ~pair_req_d};
	wire [7:0]           stat_clr    = wr_stat ? hwdata[7:0] : `EID_RST_BYTE;
	wire [7:0]           next_status = (irq_status & ~stat_clr) | evt;

	//------------------------------------------------------------
	// Bus flops
	//------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend   <= 1'b0;
			rd_pend   <= 1'b0;
			acc_addr  <= `EID_RST_BYTE;
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
			hrdata    <= 32'h00000000;
		end else begin
			wr_pend   <= acc & hwrite;
			rd_pend   <= acc & ~hwrite;
			acc_addr  <= acc ? haddr[7:0] : acc_addr;
			hreadyout <= next_hreadyout;
			hresp     <= 1'b0;
			hrdata    <= rd_pend ? rd_word : hrdata;
		end
	end

	//------------------------------------------------------------
	// Configuration registers
	//------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			detect_level_select    <= `EID_RST_LEVEL;
			ext_irq_enable         <= `EID_RST_BYTE;
			irq_control_low_pairs  <= `EID_RST_PAIR;
			irq_control_high_pairs <= `EID_RST_PAIR;
			irq_mask               <= `EID_RST_BYTE;
		end else begin
			detect_level_select    <= wr_level ? hwdata[15:0] : detect_level_select;
			ext_irq_enable         <= wr_en ? hwdata[7:0] : ext_irq_enable;
			irq_control_low_pairs  <= wr_ctl_l ? hwdata[1:0] : irq_control_low_pairs;
			irq_control_high_pairs <= wr_ctl_h ? hwdata[1:0] : irq_control_high_pairs;
			irq_mask               <= wr_mask ? hwdata[7:0] : irq_mask;
		end
	end

	//------------------------------------------------------------
	// Request and status flops
	//------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ext_irq_request_reg <= `EID_RST_BYTE;
			irq_status          <= `EID_RST_BYTE;
			pair_req_d          <= 4'h0;
			irq_req             <= 4'h0;
			irq                 <= 1'b0;
		end else begin
			ext_irq_request_reg <= next_req;
			irq_status          <= next_status;
			pair_req_d          <= pair_req;
			irq_req             <= next_irq_req;
			irq                 <= |(irq_status & irq_mask);
		end
	end

	//------------------------------------------------------------
	// Transfer flops
	//------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state    <= EID_ST_IDLE;
			cur      <= 2'h0;
			served   <= 4'h0;
			xfer_req <= 1'b0;
			xfer_num <= `EID_IRQ_FIRST;
		end else begin
			state    <= next_state;
			cur      <= start ? pick : cur;
			served   <= next_served;
			xfer_req <= start | (xfer_req & ~done);
			xfer_num <= start ? next_num : xfer_num;
		end
	end

	//------------------------------------------------------------
	// Checks
	//------------------------------------------------------------
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	a_flag_latch: assert property (|det_bus.hit
		|=> ((ext_irq_request_reg & $past(det_bus.hit)) == $past(det_bus.hit)))
		else $error("detected event not latched");

	a_flag_hold: assert property (1'b1
		|=> ((($past(ext_irq_request_reg) & ~$past(req_clr)) & ~ext_irq_request_reg) == 8'h00))
		else $error("flag dropped without a zero write");

	a_level_reset: assert property (wr_req && hwdata[0] == 1'b0 && det_bus.hit[0]
		|=> ext_irq_request_reg[0])
		else $error("active level did not re-set flag");

	a_disabled_quiet: assert property ((ext_irq_enable == 8'h00) ##1 (ext_irq_enable == 8'h00)
		|=> (irq_req == 4'h0))
		else $error("disabled channels reached the CPU");

	a_pair_direct: assert property (ext_irq_request_reg[7] && ext_irq_enable[7] && !auto_transfer_select[3]
		|=> irq_req[3])
		else $error("channel 7 missed number 28");

	a_num_range: assert property (xfer_req
		|-> (xfer_num >= `EID_IRQ_FIRST && xfer_num <= `EID_IRQ_LAST))
		else $error("transfer number out of range");

	a_xfer_first: assert property ($rose(irq_req[0]) && $past(auto_transfer_select[0])
		|-> $past(served[0]))
		else $error("handler request before transfer done");

	a_xfer_hold: assert property (xfer_req && !xfer_ack
		|=> xfer_req && $stable(xfer_num))
		else $error("transfer request dropped before ack");

	a_read_wait: assert property (acc && !hwrite
		|=> !hreadyout ##1 hreadyout)
		else $error("read wait state wrong");

	c_auto_xfer: cover property (xfer_req ##1 xfer_ack ##[1:4] irq_req[0]);
	c_direct:    cover property ($rose(irq_req[1]) && !auto_transfer_select[1]);
	c_level:     cover property (wr_req && det_bus.hit[2] ##1 ext_irq_request_reg[2]);
	c_irq:       cover property ($rose(irq));

endmodule : eid_top

// File: dv/eid_cpu_model.sv
// CPU side model that completes automatic transfers
`timescale 1ns/10ps
module eid_cpu_model (
	// Clock and reset
	input  wire logic       hclk,
	input  wire logic       hresetn,
	// Transfer handshake
	input  wire logic       xfer_req,
	input  wire logic [3:0] ack_delay,
	output logic            xfer_ack
);
	logic [3:0] cnt;

	// Ack pulse is one cycle; a fresh count per request keeps slow service honest
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cnt      <= 4'h0;
			xfer_ack <= 1'b0;
		end else if (xfer_ack) begin
			cnt      <= 4'h0;
			xfer_ack <= 1'b0;
		end else if (xfer_req) begin
			if (cnt >= ack_delay) xfer_ack <= 1'b1;
			else cnt <= cnt + 4'h1;
		end
	end
endmodule : eid_cpu_model

// File: dv/eid_tb_top.sv
// Self-checking bench of the external interrupt detector
`timescale 1ns/10ps
`include "eid_params.svh"
module eid_tb_top;
	logic        hclk, hresetn, hsel, hwrite, xfer_req, xfer_ack, irq, hreadyout, hresp;
	logic [31:0] haddr, hwdata, hrdata;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic [7:0]  pins, xfer_num;
	logic [3:0]  irq_req, ack_delay;
	int          n_fail, checked, cycles;

	eid_top u_eid_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .ext_irq_inputs(pins), .irq_req(irq_req),
		.xfer_req(xfer_req), .xfer_num(xfer_num), .xfer_ack(xfer_ack), .irq(irq));
	eid_cpu_model u_eid_cpu_model (.hclk(hclk), .hresetn(hresetn), .xfer_req(xfer_req),
		.ack_delay(ack_delay), .xfer_ack(xfer_ack));

	//------------------------------------------------------------
	// Tasks
	//------------------------------------------------------------
	task automatic print_verdict();
		if (n_fail == 0 && checked > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : print_verdict

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			n_fail++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	// Hangs are cut by the global cycle ceiling, not here
	task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
		@(posedge hclk);
		hsel   <= 1'b1;
		htrans <= 2'h2;
		hwrite <= wr;
		haddr  <= {24'h000000, a};
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		hsel   <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		rd = hrdata;
	endtask : ahb

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] x;
		ahb(1'b1, a, d, x);
	endtask : wr

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] x;
		ahb(1'b0, a, 32'h00000000, x);
		check(x, exp);
		check({31'h0, hresp}, 32'h00000000);
	endtask : rd_chk

	task automatic fire(input logic [7:0] p);
		@(posedge hclk) pins <= p;
		repeat (6) @(posedge hclk);
		pins <= 8'h00;
		repeat (6) @(posedge hclk);
	endtask : fire

	//------------------------------------------------------------
	// Clock and timeout
	//------------------------------------------------------------
	initial begin
		hclk = 1'b0;
		forever #12.5 hclk = ~hclk;
	end

	always @(posedge hclk) begin
		cycles++;
		if (cycles == 20000) begin
			n_fail++;
			print_verdict();
		end
	end

	//------------------------------------------------------------
	// Main sequence
	//------------------------------------------------------------
	initial begin
		int         m, c;
		logic [7:0] idle, ch;
		logic [1:0] md;
		hresetn = 1'b0; hsel = 1'b0; haddr = 32'h00000000; htrans = 2'h0; hwrite = 1'b0;
		hsize = 3'h2; hwdata = 32'h00000000; pins = 8'hFF; ack_delay = 4'h0;
		n_fail = 0; checked = 0; cycles = 0;
		repeat (20) @(posedge hclk);
		hresetn <= 1'b1;
		repeat (4) @(posedge hclk);
		// Reset values, unmapped slot reads zero and drops writes
		for (m = 0; m < 8; m++) rd_chk(8'(m * 4), 32'h00000000);
		wr(8'h1C, 32'hFFFFFFFF);
		rd_chk(8'h1C, 32'h00000000);
		// Every mode on all channels; idle level first, and stray flags raised under the old mode are cleared before the check
		for (m = 0; m < 4; m++) begin
			md   = m[1:0];
			idle = (m == 0 || m == 3) ? 8'hFF : 8'h00;
			@(posedge hclk) pins <= idle;
			wr(`EID_OFS_LEVEL, {16'h0000, {8{md}}});
			repeat (6) @(posedge hclk);
			wr(`EID_OFS_REQUEST, 32'h00000000);
			rd_chk(`EID_OFS_REQUEST, 32'h00000000);
			@(posedge hclk) pins <= idle ^ 8'hA5;
			repeat (6) @(posedge hclk);
			pins <= idle;
			repeat (6) @(posedge hclk);
			rd_chk(`EID_OFS_REQUEST, 32'h000000A5);
			wr(`EID_OFS_REQUEST, 32'h0000000F);
			rd_chk(`EID_OFS_REQUEST, 32'h00000005);
			wr(`EID_OFS_REQUEST, 32'h00000000);
		end
		// Active level re-sets the flag through a clear
		wr(`EID_OFS_LEVEL, 32'h00005555);
		@(posedge hclk) pins <= 8'h01;
		repeat (6) @(posedge hclk);
		wr(`EID_OFS_REQUEST, 32'h00000000);
		rd_chk(`EID_OFS_REQUEST, 32'h00000001);
		wr(`EID_OFS_LEVEL, 32'h0000AAAA);
		@(posedge hclk) pins <= 8'h00;
		repeat (6) @(posedge hclk);
		wr(`EID_OFS_REQUEST, 32'h00000000);
		rd_chk(`EID_OFS_REQUEST, 32'h00000000);
		// Disabled channels latch but stay silent
		wr(`EID_OFS_ENABLE, 32'h00000055);
		fire(8'hAA);
		rd_chk(`EID_OFS_REQUEST, 32'h000000AA);
		@(negedge hclk) check({28'h0, irq_req}, 32'h00000000);
		wr(`EID_OFS_REQUEST, 32'h00000000);
		// Odd channel of each pair reaches its number
		wr(`EID_OFS_ENABLE, 32'h000000FF);
		for (m = 0; m < 4; m++) begin
			fire(8'(8'h02 << (2 * m)));
			@(negedge hclk) check({28'h0, irq_req}, 32'(1 << m));
			check({31'h0, xfer_req}, 32'h00000000);
			wr(`EID_OFS_REQUEST, 32'h00000000);
			repeat (2) @(posedge hclk);
			@(negedge hclk) check({28'h0, irq_req}, 32'h00000000);
		end
		// Summary interrupt: masked, unmasked, cleared
		rd_chk(`EID_OFS_STATUS, 32'h0000000F);
		@(negedge hclk) check({31'h0, irq}, 32'h00000000);
		wr(`EID_OFS_MASK, 32'h00000001);
		repeat (2) @(posedge hclk);
		@(negedge hclk) check({31'h0, irq}, 32'h00000001);
		wr(`EID_OFS_STATUS, 32'h0000000F);
		repeat (2) @(posedge hclk);
		@(negedge hclk) check({31'h0, irq}, 32'h00000000);
		rd_chk(`EID_OFS_STATUS, 32'h00000000);
		// Automatic transfer first, handler after; prompt then slow service
		for (c = 0; c < 2; c++) begin
			ch = (c == 0) ? 8'h01 : 8'h80;
			ack_delay <= (c == 0) ? 4'h0 : 4'h5;
			wr((c == 0) ? `EID_OFS_CTL_LO : `EID_OFS_CTL_HI, (c == 0) ? 32'h1 : 32'h2);
			@(posedge hclk) pins <= ch;
			repeat (20) if (xfer_req !== 1'b1) @(posedge hclk);
			@(negedge hclk) check({31'h0, xfer_req}, 32'h00000001);
			check({24'h0, xfer_num}, (c == 0) ? 32'h19 : 32'h1C);
			check({28'h0, irq_req}, 32'h00000000);
			repeat (40) if (xfer_req !== 1'b0) @(posedge hclk);
			repeat (3) @(posedge hclk);
			@(negedge hclk) check({28'h0, irq_req}, (c == 0) ? 32'h1 : 32'h8);
			@(posedge hclk) pins <= 8'h00;
			rd_chk(`EID_OFS_STATUS, (c == 0) ? 32'h11 : 32'h88);
			wr(`EID_OFS_STATUS, 32'h000000FF);
			wr(`EID_OFS_REQUEST, 32'h00000000);
		end
		print_verdict();
	end
endmodule : eid_tb_top
